/* drs_pkg.sv */
// Package for the diagnostic board reset distribution and status LED block.
// Assumes a single pclk domain with APB register access and synchronous inputs.
// Behaviour
// - Back-panel pushbutton resets all board registers and the on-board processor.
// - Board drives both bus resets; neither resets any board function.
// - Both bus resets assert at power-up and while their control bit is set.
// - Tape reset asserts only from its software control bit.
// - Board fault LED lights at power-up, goes out when configuration ROM test passes.
// - Run LED lights during self-test phases before the NVRAM check and on halt; after that only once diagnostics pass and processor resumes.
// - Attention LED goes out when self-diagnostics pass, else stays lit.
// - Configuration LED goes out only when nonvolatile RAM is correctly initialised.
// - Rotary switch has five positions 0 to 4 selecting boot presets.
// - Uninitialised nonvolatile RAM forces default boot parameters.
// - On reset all three front LEDs light, then RAM test runs.
// - Failing RAM test halts self-test with all front LEDs lit.
// - Passing RAM test continues through five further checks in order.
// - Console restart command reruns the power-up self-diagnostic sequence.
// - Board generates both bus clocks.
// - Attention LED staying lit means self-test did not complete successfully.
package drs_pkg;

    // Register byte offsets.
    localparam logic [11:0] DRS_CTL1_OFF   = 12'h0_000;
    localparam logic [11:0] DRS_DIAG_OFF   = 12'h0_004;
    localparam logic [11:0] DRS_STAT_OFF   = 12'h0_008;
    localparam logic [11:0] DRS_IRQ_ST_OFF = 12'h0_00C;
    localparam logic [11:0] DRS_IRQ_EN_OFF = 12'h0_010;
    localparam logic [11:0] DRS_IRQ_CL_OFF = 12'h0_014;

    // Control register one bit positions.
    localparam int DRS_CTL1_BBUS_BIT = 0;
    localparam int DRS_CTL1_EBUS_BIT = 1;
    localparam int DRS_CTL1_TAPE_BIT = 2;

    // Diagnostic command register bit positions.
    localparam int DRS_DIAG_STEP_BIT = 0;
    localparam int DRS_DIAG_FAIL_BIT = 1;
    localparam int DRS_DIAG_ROM_BIT  = 2;
    localparam int DRS_DIAG_NVOK_BIT = 3;
    localparam int DRS_DIAG_RUN_BIT  = 4;
    localparam int DRS_DIAG_RST_BIT  = 5;

    // Interrupt event bit positions.
    localparam int DRS_EV_PASS_BIT  = 0;
    localparam int DRS_EV_FAIL_BIT  = 1;
    localparam int DRS_EV_SWCH_BIT  = 2;
    localparam int DRS_EV_WIDTH     = 3;

    // Reset values and the highest valid rotary switch position.
    localparam logic [2:0] DRS_CTL1_RST  = 3'h0;
    localparam logic [2:0] DRS_EV_RST    = 3'h0;
    localparam logic [2:0] DRS_SWITCH_MAX = 3'h4;

    // Clock divider half periods in pclk cycles.
    localparam int DRS_BCLK_HALF = 5;
    localparam int DRS_ECLK_HALF = 5;

    // Power-up bus reset pulse length.
    localparam int DRS_PU_RST_NS     = 1000;
    localparam int DRS_CLK_NS        = 10;
    localparam int DRS_PU_RST_CYCLES = (DRS_PU_RST_NS + DRS_CLK_NS - 1) / DRS_CLK_NS;

    // Self-test phases.
    typedef enum logic [3:0] {
        DRS_ST_LAMP,
        DRS_ST_RAM,
        DRS_ST_INTC,
        DRS_ST_BUSTMO,
        DRS_ST_IREG,
        DRS_ST_MAP,
        DRS_ST_NVCRC,
        DRS_ST_HALT,
        DRS_ST_DONE
    } drs_phase_t;

    // LED outputs.
    typedef struct packed {
        logic fault;
        logic run;
        logic attention;
        logic setup;
    } drs_led_t;

    // Reset outputs, active low on the wires.
    typedef struct packed {
        logic bbus_rst_n;
        logic ebus_init_n;
        logic tape_rst_n;
        logic cpu_rst_n;
    } drs_rst_t;

    // Boot selection.
    typedef struct packed {
        logic [2:0] position;
        logic       use_default;
        logic       valid;
    } drs_boot_t;

endpackage

/* drs_clkdiv.sv */
// Clock divider that produces one bus clock from pclk.
// Assumes pclk, presetn and the clock enable of the main block.
`timescale 1ns/1ns
module drs_clkdiv
    import drs_pkg::*;
#(
    parameter int HALF = 5
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // Divided clock.
    output logic      clk_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       clk;
    } drs_div_t;

    drs_div_t s_q;
    drs_div_t s_d;

    // Count half periods and toggle the output.
    always_comb begin
        s_d = s_q;
        if (s_q.cnt == 8'(HALF - 1)) begin
            s_d.cnt = 8'h00;
            s_d.clk = ~s_q.clk;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign clk_out = s_q.clk;

endmodule

/* drs_top.sv */
// Reset distribution, self-test sequencing and status LEDs of the diagnostic board.
// Assumes an APB master on pclk; the pushbutton arrives already debounced and synchronous.
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
module drs_top
    import drs_pkg::*;
#(
    parameter int PU_CYCLES = DRS_PU_RST_CYCLES
) (
    // Clock, reset, enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Board inputs.
    input  wire logic        reset_button,
    input  wire logic [2:0]  rotary_switch,
    // Reset outputs.
    output drs_rst_t         resets,
    // LEDs, high means lit.
    output drs_led_t         leds,
    // Boot selection.
    output drs_boot_t        boot,
    // Bus clocks.
    output logic             bbus_clk,
    output logic             ebus_clk,
    // Interrupt.
    output logic             irq
);

    typedef struct packed {
        logic [2:0]               ctl1;
        drs_phase_t               phase;
        logic                     rom_ok;
        logic                     nv_ok;
        logic                     resumed;
        logic                     pu_active;
        logic [15:0]              pu_cnt;
        logic [DRS_EV_WIDTH-1:0]  ev_st;
        logic [DRS_EV_WIDTH-1:0]  ev_en;
        logic [2:0]               sw_last;
        logic [31:0]              rdata;
        logic                     ready;
        logic                     slverr;
        drs_rst_t                 rst;
        drs_led_t                 led;
        drs_boot_t                boot;
        logic                     irq;
        logic                     bclk;
        logic                     eclk;
    } drs_state_t;

    drs_state_t s_q;
    drs_state_t s_d;

    logic bclk_raw;
    logic eclk_raw;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [DRS_EV_WIDTH-1:0] ev_set;
    logic [DRS_EV_WIDTH-1:0] ev_clr;

    drs_clkdiv #(.HALF(DRS_BCLK_HALF)) u_bclk (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .clk_out (bclk_raw)
    );

    drs_clkdiv #(.HALF(DRS_ECLK_HALF)) u_eclk (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .clk_out (eclk_raw)
    );

    // Access strobes; the slave takes the access in the first access cycle and raises pready one cycle later.
    assign wr_acc = psel && penable && pwrite && !s_q.ready;
    assign rd_acc = psel && penable && !pwrite && !s_q.ready;
    assign mapped = (paddr == DRS_CTL1_OFF) || (paddr == DRS_DIAG_OFF) ||
                    (paddr == DRS_STAT_OFF) || (paddr == DRS_IRQ_ST_OFF) ||
                    (paddr == DRS_IRQ_EN_OFF) || (paddr == DRS_IRQ_CL_OFF);

    // Next-state logic for the whole block.
    always_comb begin
        s_d = s_q;
        ev_set = '0;
        ev_clr = '0;
        s_d.ready = 1'b0;
        s_d.slverr = 1'b0;
        s_d.rdata = 32'h0000_0000;

        if (s_q.pu_active) begin
            if (s_q.pu_cnt == 16'(PU_CYCLES - 1)) begin
                s_d.pu_active = 1'b0;
            end else begin
                s_d.pu_cnt = s_q.pu_cnt + 16'h0001;
            end
        end

        // Register writes and the diagnostic sequencer commands.
        if (wr_acc) begin
            s_d.ready = 1'b1;
            s_d.slverr = !mapped;
            case (paddr)
                DRS_CTL1_OFF: begin
                    s_d.ctl1 = pwdata[2:0];
                end
                DRS_DIAG_OFF: begin
                    if (pwdata[DRS_DIAG_ROM_BIT]) begin
                        s_d.rom_ok = 1'b1;
                    end
                    if (pwdata[DRS_DIAG_NVOK_BIT]) begin
                        s_d.nv_ok = 1'b1;
                    end
                    if (pwdata[DRS_DIAG_RUN_BIT] && s_q.phase == DRS_ST_DONE) begin
                        s_d.resumed = 1'b1;
                    end
                    if (pwdata[DRS_DIAG_RST_BIT]) begin
                        s_d.phase = DRS_ST_LAMP;
                        s_d.rom_ok = 1'b0;
                        s_d.nv_ok = 1'b0;
                        s_d.resumed = 1'b0;
                    end else if (pwdata[DRS_DIAG_FAIL_BIT]) begin
                        case (s_q.phase)
                            DRS_ST_RAM: s_d.phase = DRS_ST_HALT;
                            DRS_ST_INTC, DRS_ST_BUSTMO, DRS_ST_IREG, DRS_ST_MAP: begin
                                s_d.phase = DRS_ST_HALT;
                            end
                            DRS_ST_NVCRC: begin
                                s_d.phase = DRS_ST_DONE;
                                s_d.nv_ok = 1'b0;
                            end
                            default: s_d.phase = s_q.phase;
                        endcase
                        ev_set[DRS_EV_FAIL_BIT] = 1'b1;
                    end else if (pwdata[DRS_DIAG_STEP_BIT]) begin
                        case (s_q.phase)
                            DRS_ST_LAMP:  s_d.phase = DRS_ST_RAM;
                            DRS_ST_RAM:   s_d.phase = DRS_ST_INTC;
                            DRS_ST_INTC:  s_d.phase = DRS_ST_BUSTMO;
                            DRS_ST_BUSTMO: s_d.phase = DRS_ST_IREG;
                            DRS_ST_IREG:  s_d.phase = DRS_ST_MAP;
                            DRS_ST_MAP:   s_d.phase = DRS_ST_NVCRC;
                            DRS_ST_NVCRC: begin
                                s_d.phase = DRS_ST_DONE;
                                s_d.nv_ok = 1'b1;
                                ev_set[DRS_EV_PASS_BIT] = 1'b1;
                            end
                            default: s_d.phase = s_q.phase;
                        endcase
                    end
                end
                DRS_IRQ_EN_OFF: s_d.ev_en = pwdata[DRS_EV_WIDTH-1:0];
                DRS_IRQ_CL_OFF: ev_clr = pwdata[DRS_EV_WIDTH-1:0];
                default: s_d.ctl1 = s_q.ctl1;
            endcase
        end

        // Register reads.
        if (rd_acc) begin
            s_d.ready = 1'b1;
            s_d.slverr = !mapped;
            case (paddr)
                DRS_CTL1_OFF:   s_d.rdata = {29'h0, s_q.ctl1};
                DRS_STAT_OFF:   s_d.rdata = {20'h0, s_q.boot, s_q.resumed,
                                             s_q.nv_ok, s_q.rom_ok, 4'(s_q.phase)};
                DRS_IRQ_ST_OFF: s_d.rdata = {29'h0, s_q.ev_st};
                DRS_IRQ_EN_OFF: s_d.rdata = {29'h0, s_q.ev_en};
                default:        s_d.rdata = 32'h0000_0000;
            endcase
        end

        // rotary switch change event
        // The power-up window only loads the position, so the zero left by reset
        // never shows up as a false change.
        if (rotary_switch != s_q.sw_last && !s_q.pu_active) begin
            ev_set[DRS_EV_SWCH_BIT] = 1'b1;
        end
        s_d.sw_last = rotary_switch;

        // Sticky events: a new event wins over a clear in the same cycle.
        s_d.ev_st = (s_q.ev_st & ~ev_clr) | ev_set;
        s_d.irq = |(s_d.ev_st & s_d.ev_en);

        // bus resets do not feed back into board state
        // bus resets from power-up or software
        s_d.rst.bbus_rst_n = !(s_q.pu_active || s_d.ctl1[DRS_CTL1_BBUS_BIT]);
        s_d.rst.ebus_init_n = !(s_q.pu_active || s_d.ctl1[DRS_CTL1_EBUS_BIT]);
        s_d.rst.tape_rst_n = !s_d.ctl1[DRS_CTL1_TAPE_BIT];
        s_d.rst.cpu_rst_n = !reset_button;

        s_d.led.fault = !s_d.rom_ok;
        // run LED after pass and resume
        s_d.led.run = (s_d.phase == DRS_ST_DONE) ? s_d.resumed : (s_d.phase != DRS_ST_NVCRC);
        if (s_d.phase == DRS_ST_DONE || s_d.phase == DRS_ST_HALT) begin
            s_d.led.run = (s_d.phase == DRS_ST_HALT && s_q.phase == DRS_ST_RAM) ||
                          (s_d.phase == DRS_ST_HALT && s_q.led.run && !s_q.led.attention) ||
                          (s_d.phase == DRS_ST_DONE && s_d.resumed);
        end
        s_d.led.attention = (s_d.phase != DRS_ST_DONE);
        // setup LED until nonvolatile RAM ok
        s_d.led.setup = !s_d.nv_ok;
        if (s_d.phase == DRS_ST_HALT) begin
            s_d.led.run = 1'b1;
            s_d.led.attention = 1'b1;
            s_d.led.setup = 1'b1;
        end

        s_d.boot.valid = (rotary_switch <= DRS_SWITCH_MAX);
        s_d.boot.position = (rotary_switch <= DRS_SWITCH_MAX) ? rotary_switch : 3'h0;
        s_d.boot.use_default = !s_d.nv_ok;

        s_d.bclk = bclk_raw;
        s_d.eclk = eclk_raw;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctl1 <= DRS_CTL1_RST;
            s_q.phase <= DRS_ST_LAMP;
            s_q.pu_active <= 1'b1;
            s_q.ev_st <= DRS_EV_RST;
            s_q.ev_en <= DRS_EV_RST;
            s_q.led <= 4'hF;
            s_q.boot.use_default <= 1'b1;
            s_q.rst.tape_rst_n <= 1'b1;
        end else if (reset_button && clk_en) begin
            s_q <= '0;
            s_q.ctl1 <= DRS_CTL1_RST;
            s_q.phase <= DRS_ST_LAMP;
            s_q.pu_active <= 1'b1;
            s_q.led <= 4'hF;
            s_q.boot.use_default <= 1'b1;
            s_q.rst.tape_rst_n <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign resets = s_q.rst;
    assign leds = s_q.led;
    assign boot = s_q.boot;
    assign bbus_clk = s_q.bclk;
    assign ebus_clk = s_q.eclk;
    assign irq = s_q.irq;

endmodule

/* drs_top_asserts.sv */
// Concurrent checks on the ports of the reset distribution and status LED block.
// Assumes clk_en stays high, so the block never stalls an APB transfer.
`timescale 1ns/1ns
module drs_top_asserts
    import drs_pkg::*;
#(
    parameter int PU_CYCLES = 4
) (
    // Clock, reset and APB request.
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    // Board side.
    input wire logic        reset_button,
    input wire logic [2:0]  rotary_switch,
    input wire drs_rst_t    resets,
    input wire drs_led_t    leds,
    input wire drs_boot_t   boot,
    input wire logic        bbus_clk
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Cycles since power-up and since any board reset, and the last control word taken.
    logic       wr_done;
    logic       rom_wr;
    logic [7:0] pu_q;
    logic [7:0] up_q;
    logic [2:0] csr_q;
    // The block takes a write in the first access cycle, one edge before pready shows.
    assign wr_done = psel && penable && !pready && pwrite;
    assign rom_wr  = wr_done && paddr == DRS_DIAG_OFF && pwdata[DRS_DIAG_ROM_BIT];

    // The counters saturate so that long runs never wrap into the power-up window again.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_q  <= '0;
            up_q  <= '0;
            csr_q <= '0;
        end else begin
            pu_q <= (pu_q < 8'd200) ? pu_q + 8'd1 : pu_q;
            up_q <= reset_button ? 8'd0 : (up_q < 8'd200) ? up_q + 8'd1 : up_q;
            if (reset_button)
                csr_q <= '0;
            else if (wr_done && paddr == DRS_CTL1_OFF)
                csr_q <= pwdata[2:0];
        end
    end

    property p_apb_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready not one cycle into access");

    property p_button;
        reset_button |=> !resets.cpu_rst_n && leds == 4'hF;
    endproperty
    a_button: assert property (p_button) else $error("button did not reset board");

    property p_power_up;
        pu_q < PU_CYCLES |-> !resets.bbus_rst_n && !resets.ebus_init_n;
    endproperty
    a_power_up: assert property (p_power_up) else $error("bus reset released early");

    property p_bbus;
        up_q > PU_CYCLES + 2 && $stable(csr_q) && csr_q == $past(csr_q, 2)
            |-> resets.bbus_rst_n == !csr_q[DRS_CTL1_BBUS_BIT];
    endproperty
    a_bbus: assert property (p_bbus) else $error("backplane reset not following control");

    property p_tape;
        up_q > 2 && $stable(csr_q) && csr_q == $past(csr_q, 2)
            |-> resets.tape_rst_n == !csr_q[DRS_CTL1_TAPE_BIT];
    endproperty
    a_tape: assert property (p_tape) else $error("tape reset not following control");

    property p_lamp;
        pu_q < 2 && up_q < 2 |-> leds == 4'hF;
    endproperty
    a_lamp: assert property (p_lamp) else $error("LEDs not all lit after reset");

    property p_fault;
        $fell(leds.fault) |-> $past(rom_wr) || $past(rom_wr, 2);
    endproperty
    a_fault: assert property (p_fault) else $error("fault LED off without ROM pass");

    property p_switch;
        up_q > 2 && rotary_switch <= DRS_SWITCH_MAX && $stable(rotary_switch)
            && rotary_switch == $past(rotary_switch, 2)
            |-> boot.valid && boot.position == rotary_switch;
    endproperty
    a_switch: assert property (p_switch) else $error("boot position wrong");

    property p_bclk;
        up_q > 2 && $changed(bbus_clk) |=> $stable(bbus_clk) [*4] ##1 $changed(bbus_clk);
    endproperty
    a_bclk: assert property (p_bclk) else $error("backplane clock period wrong");
endmodule

/* drs_far_model.sv */
// Far-side loads of the block: backplane and expansion boards that count clock edges.
// Assumes the bus clocks come straight from the block's pins.
`timescale 1ns/1ns
module drs_far_model
    import drs_pkg::*;
(
    // Clocks received by the loads.
    input  wire logic        bbus_clk,
    input  wire logic        ebus_clk,
    // Edge counts, free running, so the bench checks differences.
    output logic      [15:0] bclk_edges,
    output logic      [15:0] eclk_edges
);
    // Counters start at zero so that the differences the bench takes are defined.
    logic [15:0] b_q = 16'h0000;
    logic [15:0] e_q = 16'h0000;

    always @(posedge bbus_clk) b_q <= b_q + 16'h0001;
    always @(posedge ebus_clk) e_q <= e_q + 16'h0001;
    assign bclk_edges = b_q;
    assign eclk_edges = e_q;
endmodule

/* drs_top_test.sv */
// Self-checking bench for drs_top with the far-side model and the bound checker.
// Assumes one 100 MHz clock and a shortened power-up bus reset window.
`timescale 1ns/1ns
module drs_top_test
    import drs_pkg::*;
;
    localparam int PU = 4;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, reset_button;
    logic        pready, pslverr, bbus_clk, ebus_clk, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  rotary_switch, v;
    logic [7:0]  lf;
    logic [15:0] bce, ece, b0, e0;
    drs_rst_t    resets;
    drs_led_t    leds;
    drs_boot_t   boot;
    int          n_mismatch, check_count;

    drs_top #(.PU_CYCLES(PU)) u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_button, .rotary_switch,
        .resets, .leds, .boot, .bbus_clk, .ebus_clk, .irq);
    drs_far_model u_far (.bbus_clk, .ebus_clk, .bclk_edges(bce), .eclk_edges(ece));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Reset pins are active low, so each written bit shows inverted.
    function automatic logic [31:0] exp_rst(input logic [2:0] b);
        return 32'({~b[0], ~b[1], ~b[2]});
    endfunction

    function automatic logic [31:0] exp_phase(input int k);
        return (k == 7) ? 32'(DRS_ST_DONE) : 32'(k);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Holds the request until pready is seen high at a rising edge, then releases it.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no pready", $time);
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounds the whole run so a hang still reaches the verdict.
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        n_mismatch = 0;
        check_count = 0;
        lf = 8'h30;
        {presetn, psel, penable, pwrite, reset_button} = '0;
        clk_en = 1'b1;
        paddr = '0;
        pwdata = '0;
        rotary_switch = 3'h2;
        repeat (12) @(posedge pclk);
        chk(32'(leds), 32'(4'hF), "LEDs in reset");
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(resets.bbus_rst_n), 32'h0, "bus reset at power-up");
        repeat (PU + 4) @(posedge pclk);
        chk(32'(resets), 32'(4'hF), "resets released");
        $display("test power_up done");
        // pins follow control register one, corners then random values.
        for (int i = 0; i < 8; i++) begin
            lf = lfsr(lf);
            v = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : lf[2:0];
            apb(1'b1, DRS_CTL1_OFF, 32'(v));
            repeat (2) @(posedge pclk);
            chk(32'({resets.bbus_rst_n, resets.ebus_init_n, resets.tape_rst_n}), exp_rst(v), "pins");
            apb(1'b0, DRS_CTL1_OFF, 32'h0);
            chk(rd, 32'(v), "ctl1 read");
        end
        apb(1'b1, DRS_CTL1_OFF, 32'h0);
        apb(1'b0, 12'hFF0, 32'h0);
        chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
        $display("test ctl1 done");
        // full passing self-test with the pass event enabled.
        apb(1'b1, DRS_IRQ_EN_OFF, 32'h0000_0001);
        apb(1'b0, DRS_STAT_OFF, 32'h0);
        chk(32'(rd[3:0]), 32'(DRS_ST_LAMP), "lamp phase");
        chk(32'(boot.use_default), 32'h1, "default boot");
        apb(1'b1, DRS_DIAG_OFF, 32'h0000_0004);
        repeat (2) @(posedge pclk);
        chk(32'(leds.fault), 32'h0, "fault LED");
        for (int k = 1; k < 8; k++) begin
            if (k == 7)
                apb(1'b1, DRS_DIAG_OFF, 32'h0000_0008);
            apb(1'b1, DRS_DIAG_OFF, 32'h0000_0001);
            apb(1'b0, DRS_STAT_OFF, 32'h0);
            chk(32'(rd[3:0]), exp_phase(k), "phase");
            if (k == 1)
                chk(32'(leds), 32'(4'h7), "lamps in RAM test");
        end
        chk(32'({leds, irq, boot.use_default}), 32'(6'h02), "done LEDs");
        apb(1'b1, DRS_DIAG_OFF, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        chk(32'(leds), 32'(4'h4), "run LED");
        apb(1'b1, DRS_IRQ_CL_OFF, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0, "irq cleared");
        $display("test pass_path done");
        // failing RAM test after a restart, with the fail event masked.
        apb(1'b1, DRS_DIAG_OFF, 32'h0000_0020);
        apb(1'b1, DRS_IRQ_EN_OFF, 32'h0000_0004);
        apb(1'b0, DRS_STAT_OFF, 32'h0);
        chk(32'({rd[3:0], leds.run, leds.attention, leds.setup}), 32'(7'h07), "restart");
        apb(1'b1, DRS_DIAG_OFF, 32'h0000_0001);
        apb(1'b1, DRS_DIAG_OFF, 32'h0000_0002);
        apb(1'b1, DRS_CTL1_OFF, 32'h0000_0003);
        apb(1'b0, DRS_STAT_OFF, 32'h0);
        chk(32'({rd[3:0], leds.run, leds.attention, leds.setup, irq}), 32'(8'h7E), "halt");
        apb(1'b0, DRS_IRQ_ST_OFF, 32'h0);
        chk(32'(rd[DRS_EV_FAIL_BIT]), 32'h1, "fail event");
        apb(1'b1, DRS_CTL1_OFF, 32'h0);
        lf = lfsr(lf);
        v = (lf[1:0] == 2'h2) ? 3'h4 : 3'(lf[1:0]);
        rotary_switch <= v;
        repeat (4) @(posedge pclk);
        chk(32'({boot.position, boot.valid, irq}), 32'({v, 2'h3}), "switch");
        rotary_switch <= 3'h5;
        repeat (4) @(posedge pclk);
        chk(32'(boot.valid), 32'h0, "invalid switch");
        $display("test fail_path done");
        // pushbutton returns registers to their power-up state.
        apb(1'b1, DRS_CTL1_OFF, 32'h0000_0007);
        reset_button <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'({resets.cpu_rst_n, leds}), 32'(5'h0F), "button held");
        reset_button <= 1'b0;
        repeat (PU + 8) @(posedge pclk);
        apb(1'b0, DRS_CTL1_OFF, 32'h0);
        chk({rd[30:0], resets.tape_rst_n}, 32'h1, "after button");
        b0 = bce;
        e0 = ece;
        repeat (100) @(posedge pclk);
        chk(32'({bce - b0, ece - e0}), 32'h000A_000A, "bus clocks");
        $display("test button_clocks done");
        stop_test();
    end
endmodule

bind drs_top drs_top_asserts #(.PU_CYCLES(PU_CYCLES)) u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .reset_button, .rotary_switch, .resets, .leds, .boot,
    .bbus_clk);
